// file: core/gpint_defs.svh
// Constants of the pin interrupt block: widths, register byte addresses,
// reset values and bus field positions.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef GPINT_DEFS_SVH
`define GPINT_DEFS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define GPINT_WIDTH          16
`define GPINT_ADDR_WIDTH     32
`define GPINT_DATA_WIDTH     32

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define GPINT_ADDR_DIRECTION 32'hc300_0004
`define GPINT_ADDR_ENABLE    32'hc300_0030
`define GPINT_ADDR_MASK      32'hc300_0034
`define GPINT_ADDR_TYPE      32'hc300_0038
`define GPINT_ADDR_POLARITY  32'hc300_003c
`define GPINT_ADDR_MASKED    32'hc300_0040
`define GPINT_ADDR_RAW       32'hc300_0044
`define GPINT_ADDR_CLEAR     32'hc300_004c

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define GPINT_RESET_WORD     16'h0000
`define GPINT_RESET_BIT      1'b0
`define GPINT_LOW_BYTE_HI    7
`define GPINT_HIGH_BYTE_LO   8
`define GPINT_WORD_ALIGN     2'b00

`endif

// file: core/gpint_pkg.sv
// Types shared by the pin interrupt block.
// Assumes gpint_defs.svh is on the include path.
`include "gpint_defs.svh"

package gpint_pkg;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef logic [`GPINT_WIDTH-1:0]      gpint_bits_t;
    typedef logic [`GPINT_ADDR_WIDTH-1:0] gpint_addr_t;
    typedef logic [`GPINT_DATA_WIDTH-1:0] gpint_data_t;

    // Response codes of the register bus.
    typedef enum logic [1:0]
    {
        GPINT_RESP_OKAY   = 2'b00,
        GPINT_RESP_SLVERR = 2'b10
    } gpint_resp_t;

endpackage

// file: core/gpint_bit.sv
// Interrupt detector for one pin: level or edge, either polarity.
// Assumes the pin is synchronous to clock and the controls are registered.
`timescale 1ns/1ps
`default_nettype none

`include "gpint_defs.svh"

module gpint_bit
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic pin,
    input  wire logic qualified,
    input  wire logic edge_type,
    input  wire logic active_high,
    input  wire logic clear,
    output var  logic flag
);
    import gpint_pkg::*;

    logic prev_pin;
    logic next_prev_pin;
    logic next_flag;
    logic hit_level;
    logic hit_edge;

    // ****************************************************************
    // Detection
    // ****************************************************************
    // Polarity picks the active level; an edge is a change into it.
    always_comb
    begin
        hit_level     = (pin == active_high); // [RULE_02]
        hit_edge      = (pin != prev_pin) && hit_level; // [RULE_02]
        next_prev_pin = pin;
        if (!qualified)
        begin
            // An unqualified pin holds its flag cleared.
            next_flag = `GPINT_RESET_BIT; // [RULE_06] [RULE_07]
        end
        else if (edge_type) // [RULE_01]
        begin
            // A new edge wins over a clear in the same cycle.
            next_flag = hit_edge || (flag && !clear); // [RULE_07] [RULE_08]
        end
        else
        begin
            next_flag = hit_level; // [RULE_01] [RULE_08]
        end
    end

    // The pin history runs through reset too, so the first cycle after
    // release compares against the real pin and sees no false edge.
    always_ff @(posedge clock)
    begin
        prev_pin <= next_prev_pin;
    end

    // Registers only.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            flag <= `GPINT_RESET_BIT;
        end
        else
        begin
            flag <= next_flag;
        end
    end

endmodule

`default_nettype wire

// file: core/gpint_top.sv
// Interrupt type, polarity and status part of a 16-bit pin port, with an
// AXI4-Lite register slave and one level interrupt output.
// Assumes pins are synchronous to clock; one bus master drives the slave.
// Function
// [RULE_01] Type bit 0 selects level, 1 selects edge; resets to level.
// [RULE_02] Polarity bit 0 is falling or low, 1 rising or high; reset low.
// [RULE_03] Type, polarity, masked status exist only in interrupt builds.
// [RULE_04] Read-only masked status shows interrupt state after masking.
// [RULE_05] Read-only raw status shows interrupt state before masking.
// [RULE_06] A bit detects only when enabled and its direction is input.
// [RULE_07] Writing one clears a latched edge; unconfigured bits stay clear.
// [RULE_08] Edges latch until cleared; levels follow the pin; mask forces zero.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "gpint_defs.svh"

module gpint_top
#(
    parameter bit INT_BUILT = 1'b1
)
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire gpint_pkg::gpint_bits_t gpio_pins,
    input  wire gpint_pkg::gpint_addr_t s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output var  logic                 s_axi_awready,
    input  wire gpint_pkg::gpint_data_t s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output var  logic                 s_axi_wready,
    output var  gpint_pkg::gpint_resp_t s_axi_bresp,
    output var  logic                 s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire gpint_pkg::gpint_addr_t s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output var  logic                 s_axi_arready,
    output var  gpint_pkg::gpint_data_t s_axi_rdata,
    output var  gpint_pkg::gpint_resp_t s_axi_rresp,
    output var  logic                 s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output var  logic                 irq
);
    import gpint_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    gpint_bits_t port_direction;
    gpint_bits_t interrupt_enable;
    gpint_bits_t interrupt_mask_bits;
    gpint_bits_t interrupt_type_select;
    gpint_bits_t interrupt_polarity_select;
    gpint_bits_t edge_interrupt_clear;
    gpint_bits_t raw_interrupt_flags;
    gpint_bits_t masked_interrupt_flags;
    gpint_bits_t qualified;

    gpint_bits_t next_port_direction;
    gpint_bits_t next_interrupt_enable;
    gpint_bits_t next_interrupt_mask_bits;
    gpint_bits_t next_interrupt_type_select;
    gpint_bits_t next_interrupt_polarity_select;
    gpint_bits_t next_edge_interrupt_clear;

    logic        aw_held;
    logic        w_held;
    gpint_addr_t aw_addr;
    gpint_data_t w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic        next_w_held;
    gpint_addr_t next_aw_addr;
    gpint_data_t next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_awready;
    logic        next_wready;
    logic        next_bvalid;
    gpint_resp_t next_bresp;
    logic        next_arready;
    logic        next_rvalid;
    gpint_data_t next_rdata;
    gpint_resp_t next_rresp;
    logic        next_irq;
    gpint_addr_t write_word;
    gpint_addr_t read_word;

    // Merges the two low byte lanes of a write into a stored word.
    function automatic gpint_bits_t merge_lanes
    (
        input gpint_bits_t old_value,
        input gpint_data_t data,
        input logic [3:0]  strb
    );
        gpint_bits_t result;
        result = old_value;
        if (strb[0])
        begin
            result[`GPINT_LOW_BYTE_HI:0] = data[`GPINT_LOW_BYTE_HI:0];
        end
        if (strb[1])
        begin
            result[`GPINT_WIDTH-1:`GPINT_HIGH_BYTE_LO] =
                data[`GPINT_WIDTH-1:`GPINT_HIGH_BYTE_LO];
        end
        return result;
    endfunction

    // ****************************************************************
    // Per-pin detectors
    // ****************************************************************
    // A pin joins detection only when enabled, an input, and the port
    // was built with interrupts; everything else reads as zero.
    assign qualified = interrupt_enable & ~port_direction
                     & {`GPINT_WIDTH{INT_BUILT}}; // [RULE_06] [RULE_03]
    // The mask only hides bits; the raw view keeps them visible.
    assign masked_interrupt_flags = raw_interrupt_flags
                                  & ~interrupt_mask_bits; // [RULE_08]

    for (genvar i = 0; i < `GPINT_WIDTH; i++)
    begin : g_pin
        gpint_bit u_bit
        (
            .clock       (clock),
            .reset       (reset),
            .pin         (gpio_pins[i]),
            .qualified   (qualified[i]),
            .edge_type   (interrupt_type_select[i]),
            .active_high (interrupt_polarity_select[i]),
            .clear       (edge_interrupt_clear[i]),
            .flag        (raw_interrupt_flags[i])
        );
    end

    // ****************************************************************
    // Write channel
    // ****************************************************************
    assign write_word = {aw_addr[`GPINT_ADDR_WIDTH-1:2], `GPINT_WORD_ALIGN};

    // Address and data are taken in either order and held until both
    // are present; the register update and response follow a cycle later.
    always_comb
    begin
        next_aw_held                   = aw_held;
        next_w_held                    = w_held;
        next_aw_addr                   = aw_addr;
        next_w_data                    = w_data;
        next_w_strb                    = w_strb;
        next_bvalid                    = s_axi_bvalid;
        next_bresp                     = s_axi_bresp;
        next_port_direction            = port_direction;
        next_interrupt_enable          = interrupt_enable;
        next_interrupt_mask_bits       = interrupt_mask_bits;
        next_interrupt_type_select     = interrupt_type_select;
        next_interrupt_polarity_select = interrupt_polarity_select;
        next_edge_interrupt_clear      = `GPINT_RESET_WORD;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = GPINT_RESP_OKAY;
            if (write_word == `GPINT_ADDR_DIRECTION)
            begin
                next_port_direction =
                    merge_lanes(port_direction, w_data, w_strb);
            end
            else if (write_word == `GPINT_ADDR_ENABLE)
            begin
                next_interrupt_enable =
                    merge_lanes(interrupt_enable, w_data, w_strb);
            end
            else if (write_word == `GPINT_ADDR_CLEAR)
            begin
                // One-cycle pulse; a set in the same cycle still wins.
                next_edge_interrupt_clear = merge_lanes(`GPINT_RESET_WORD,
                    w_data, w_strb); // [RULE_07]
            end
            else if (write_word == `GPINT_ADDR_RAW)
            begin
                // Read-only: the write is acknowledged and dropped.
                next_bresp = GPINT_RESP_OKAY; // [RULE_05]
            end
            else if (INT_BUILT && write_word == `GPINT_ADDR_MASK)
            begin
                next_interrupt_mask_bits =
                    merge_lanes(interrupt_mask_bits, w_data, w_strb);
            end
            else if (INT_BUILT && write_word == `GPINT_ADDR_TYPE)
            begin
                next_interrupt_type_select = merge_lanes(
                    interrupt_type_select, w_data, w_strb); // [RULE_01]
            end
            else if (INT_BUILT && write_word == `GPINT_ADDR_POLARITY)
            begin
                next_interrupt_polarity_select = merge_lanes(
                    interrupt_polarity_select, w_data, w_strb); // [RULE_02]
            end
            else if (INT_BUILT && write_word == `GPINT_ADDR_MASKED)
            begin
                next_bresp = GPINT_RESP_OKAY; // [RULE_04]
            end
            else
            begin
                // Unmapped, or absent because interrupts are not built.
                next_bresp = GPINT_RESP_SLVERR; // [RULE_03]
            end
        end
        // No new request is taken while one is held or answered.
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
    end

    // ****************************************************************
    // Read channel and interrupt output
    // ****************************************************************
    assign read_word = {s_axi_araddr[`GPINT_ADDR_WIDTH-1:2],
                        `GPINT_WORD_ALIGN};

    // Read data is captured at the address handshake, so the answer
    // shows the state of that very cycle.
    always_comb
    begin
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = '0;
            next_rresp   = GPINT_RESP_OKAY;
            if (read_word == `GPINT_ADDR_DIRECTION)
            begin
                next_rdata[`GPINT_WIDTH-1:0] = port_direction;
            end
            else if (read_word == `GPINT_ADDR_ENABLE)
            begin
                next_rdata[`GPINT_WIDTH-1:0] = interrupt_enable;
            end
            else if (read_word == `GPINT_ADDR_CLEAR)
            begin
                // Write-only register reads as zero.
                next_rdata[`GPINT_WIDTH-1:0] = `GPINT_RESET_WORD;
            end
            else if (read_word == `GPINT_ADDR_RAW)
            begin
                next_rdata[`GPINT_WIDTH-1:0] =
                    raw_interrupt_flags; // [RULE_05]
            end
            else if (INT_BUILT && read_word == `GPINT_ADDR_MASK)
            begin
                next_rdata[`GPINT_WIDTH-1:0] = interrupt_mask_bits;
            end
            else if (INT_BUILT && read_word == `GPINT_ADDR_TYPE)
            begin
                next_rdata[`GPINT_WIDTH-1:0] = interrupt_type_select;
            end
            else if (INT_BUILT && read_word == `GPINT_ADDR_POLARITY)
            begin
                next_rdata[`GPINT_WIDTH-1:0] = interrupt_polarity_select;
            end
            else if (INT_BUILT && read_word == `GPINT_ADDR_MASKED)
            begin
                next_rdata[`GPINT_WIDTH-1:0] =
                    masked_interrupt_flags; // [RULE_04]
            end
            else
            begin
                next_rresp = GPINT_RESP_SLVERR; // [RULE_03]
            end
        end
        next_irq = |masked_interrupt_flags; // [RULE_08]
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // All state takes its documented default under reset.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            aw_held                   <= 1'b0;
            w_held                    <= 1'b0;
            aw_addr                   <= '0;
            w_data                    <= '0;
            w_strb                    <= '0;
            s_axi_awready             <= 1'b1;
            s_axi_wready              <= 1'b1;
            s_axi_bvalid              <= 1'b0;
            s_axi_bresp               <= GPINT_RESP_OKAY;
            s_axi_arready             <= 1'b1;
            s_axi_rvalid              <= 1'b0;
            s_axi_rdata               <= '0;
            s_axi_rresp               <= GPINT_RESP_OKAY;
            irq                       <= 1'b0;
            port_direction            <= `GPINT_RESET_WORD;
            interrupt_enable          <= `GPINT_RESET_WORD;
            interrupt_mask_bits       <= `GPINT_RESET_WORD;
            interrupt_type_select     <= `GPINT_RESET_WORD; // [RULE_01]
            interrupt_polarity_select <= `GPINT_RESET_WORD; // [RULE_02]
            edge_interrupt_clear      <= `GPINT_RESET_WORD;
        end
        else
        begin
            aw_held                   <= next_aw_held;
            w_held                    <= next_w_held;
            aw_addr                   <= next_aw_addr;
            w_data                    <= next_w_data;
            w_strb                    <= next_w_strb;
            s_axi_awready             <= next_awready;
            s_axi_wready              <= next_wready;
            s_axi_bvalid              <= next_bvalid;
            s_axi_bresp               <= next_bresp;
            s_axi_arready             <= next_arready;
            s_axi_rvalid              <= next_rvalid;
            s_axi_rdata               <= next_rdata;
            s_axi_rresp               <= next_rresp;
            irq                       <= next_irq;
            port_direction            <= next_port_direction;
            interrupt_enable          <= next_interrupt_enable;
            interrupt_mask_bits       <= next_interrupt_mask_bits;
            interrupt_type_select     <= next_interrupt_type_select;
            interrupt_polarity_select <= next_interrupt_polarity_select;
            edge_interrupt_clear      <= next_edge_interrupt_clear;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // An independent edge and level model checks the detectors.
    gpint_bits_t pins_seen;
    gpint_bits_t level_hit;
    gpint_bits_t edge_hit;

    always_ff @(posedge clock)
    begin
        pins_seen <= gpio_pins;
    end

    assign level_hit = qualified & ~(gpio_pins ^ interrupt_polarity_select);
    assign edge_hit  = level_hit & (gpio_pins ^ pins_seen);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_reset_defaults: assert property ( // [RULE_01]
        $past(reset) |-> interrupt_type_select == `GPINT_RESET_WORD
                      && interrupt_polarity_select == `GPINT_RESET_WORD)
        else $error("Type or polarity not at default after reset.");

    a_level_follow: assert property ( // [RULE_02]
        ##1 (raw_interrupt_flags & ~$past(interrupt_type_select))
            == ($past(level_hit) & ~$past(interrupt_type_select)))
        else $error("Level flag does not follow the active pin level.");

    a_build_absent: assert property ( // [RULE_03]
        !INT_BUILT |-> raw_interrupt_flags == `GPINT_RESET_WORD
                    && interrupt_type_select == `GPINT_RESET_WORD)
        else $error("Interrupt state present without interrupt build.");

    a_masked_read: assert property ( // [RULE_04]
        INT_BUILT && s_axi_arvalid && s_axi_arready
            && read_word == `GPINT_ADDR_MASKED
        |=> s_axi_rvalid && s_axi_rdata[`GPINT_WIDTH-1:0]
            == $past(raw_interrupt_flags & ~interrupt_mask_bits))
        else $error("Masked status read returned wrong value.");

    a_raw_read: assert property ( // [RULE_05]
        s_axi_arvalid && s_axi_arready && read_word == `GPINT_ADDR_RAW
        |=> s_axi_rvalid && s_axi_rresp == GPINT_RESP_OKAY
            && s_axi_rdata[`GPINT_WIDTH-1:0] == $past(raw_interrupt_flags))
        else $error("Raw status read returned wrong value.");

    a_unqual_clear: assert property ( // [RULE_06]
        ##1 (raw_interrupt_flags & ~$past(qualified)) == `GPINT_RESET_WORD)
        else $error("Flag set on a disabled or output pin.");

    a_edge_clear: assert property ( // [RULE_07]
        ##1 (raw_interrupt_flags & $past(edge_interrupt_clear
            & interrupt_type_select & ~edge_hit)) == `GPINT_RESET_WORD)
        else $error("Edge flag survived a clear without a new edge.");

    a_edge_latch: assert property ( // [RULE_08]
        ##1 (~raw_interrupt_flags & $past(interrupt_type_select
            & (edge_hit | (raw_interrupt_flags & qualified
            & ~edge_interrupt_clear)))) == `GPINT_RESET_WORD)
        else $error("Edge flag not set or not held.");

    a_irq_level: assert property ( // [RULE_08]
        ##1 irq == $past(|(raw_interrupt_flags & ~interrupt_mask_bits)))
        else $error("Interrupt output disagrees with masked status.");

    a_write_answer: assert property (
        aw_held && w_held && !s_axi_bvalid |=> s_axi_bvalid [*1])
        else $error("Write response missing after address and data.");

    c_edge_latched: cover property (
        |(interrupt_type_select & raw_interrupt_flags) ##1
        |(interrupt_type_select & raw_interrupt_flags));
    c_irq_raised: cover property ($rose(irq));
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_read_error: cover property (
        s_axi_rvalid && s_axi_rresp == GPINT_RESP_SLVERR);

endmodule

`default_nettype wire

// file: tb/gpint_pins.sv
// Far-side model: the sixteen port pins.
// Assumes the bench hands it new levels just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module gpint_pins
(
    input  wire gpint_pkg::gpint_bits_t level,
    output var  gpint_pkg::gpint_bits_t gpio_pins
);
    import gpint_pkg::*;
    // Pins are driven, never released, so no idle level arises.
    always_comb gpio_pins = level;
endmodule
`default_nettype wire

// file: tb/gpint_top_test.sv
// Self-checking bench of the pin interrupt block.
// Assumes gpint_defs.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "gpint_defs.svh"
module gpint_top_test;
    import gpint_pkg::*;
    logic        clock = 0, reset = 1, irq;
    gpint_bits_t level = '0, gpio_pins, e = '0, pv = '0, n, q, raw;
    gpint_bits_t v[5];
    gpint_addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
    gpint_data_t s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    gpint_resp_t s_axi_bresp, s_axi_rresp, r;
    int          failures = 0, comparisons = 0;
    bit [31:0]   seed = 32'h38e8;
    gpint_addr_t cfg[5] = '{`GPINT_ADDR_DIRECTION, `GPINT_ADDR_ENABLE,
        `GPINT_ADDR_MASK, `GPINT_ADDR_TYPE, `GPINT_ADDR_POLARITY};
    gpint_top gpint_top_inst (.*);
    gpint_pins gpint_pins_inst (.level(level), .gpio_pins(gpio_pins));
    initial forever #12.5 clock = ~clock;
    function automatic bit [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task check(input gpint_data_t s, input gpint_data_t x);
        comparisons++;
        if (s !== x)
        begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, s, x);
        end
    endtask
    // Bus master: each channel drops its valid once taken.
    task wr(input gpint_addr_t a, input gpint_data_t w);
        s_axi_awaddr <= a;
        s_axi_wdata <= w;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
        @(posedge clock);
    endtask
    task rd(input gpint_addr_t a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        @(posedge clock);
    endtask
    task test_done();
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // A hang past twenty thousand cycles ends the run.
    initial
    begin
        #500000;
        failures++;
        test_done();
    end
    // Random configurations and pins against an integer model.
    initial
    begin
        repeat (6) @(posedge clock);
        reset <= 0;
        @(posedge clock);
        rd(`GPINT_ADDR_TYPE);
        check(d, 32'h0);
        rd(`GPINT_ADDR_POLARITY);
        check(d, 32'h0);
        rd(32'hc300_00f0);
        check(32'(r), 32'(GPINT_RESP_SLVERR));
        wr(32'hc300_00f0, 32'h0);
        check(32'(r), 32'(GPINT_RESP_SLVERR));
        for (int i = 0; i < 24; i++)
        begin
            if (i % 6 == 0)
            begin
                foreach (v[k])
                begin
                    v[k] = 16'(xs());
                    wr(cfg[k], {16'h0, v[k]});
                end
                wr(`GPINT_ADDR_CLEAR, 32'hffff);
                e = '0;
                rd(`GPINT_ADDR_TYPE);
                check(d, {16'h0, v[3]});
                rd(`GPINT_ADDR_POLARITY);
                check(d, {16'h0, v[4]});
            end
            // Edges latch only on a move into the active level.
            n = 16'(xs());
            level <= n;
            q = v[1] & ~v[0];
            e |= q & v[3] & ~(n ^ v[4]) & (pv ^ v[4]);
            pv = n;
            raw = (q & ~v[3] & ~(n ^ v[4])) | e;
            repeat (3) @(posedge clock);
            wr(`GPINT_ADDR_RAW, 32'hffff);
            check(32'(r), 32'(GPINT_RESP_OKAY));
            rd(`GPINT_ADDR_RAW);
            check(d, {16'h0, raw});
            rd(`GPINT_ADDR_MASKED);
            check(d, {16'h0, raw & ~v[2]});
            check(32'(irq), 32'(|(raw & ~v[2])));
            n = 16'(xs());
            wr(`GPINT_ADDR_CLEAR, {16'h0, n});
            e &= ~n;
        end
        // A reset in mid-run must bring back the defaults and clear flags.
        reset <= 1;
        repeat (2) @(posedge clock);
        reset <= 0;
        @(posedge clock);
        rd(`GPINT_ADDR_TYPE);
        check(d, 32'h0);
        rd(`GPINT_ADDR_POLARITY);
        check(d, 32'h0);
        rd(`GPINT_ADDR_RAW);
        check(d, 32'h0);
        check(32'(irq), 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
